// file: rtl/tpdi_pkg.sv
// Package for the pen touch detect and interrupt block.
package tpdi_pkg;

  // Control byte layout: start bit, channel select, mode, ser/dfr, power.
  localparam int unsigned TPDI_CTRL_W = 8;
  localparam int unsigned TPDI_START_POS = 7;
  localparam int unsigned TPDI_CHAN_HI = 6;
  localparam int unsigned TPDI_CHAN_LO = 4;
  localparam int unsigned TPDI_MODE8_POS = 3;
  localparam int unsigned TPDI_REFPWR_POS = 1;
  localparam int unsigned TPDI_PDSEL_POS = 0;

  // Channel select codes that are panel position measurements.
  localparam logic [2:0] TPDI_CH_Y = 3'h1;
  localparam logic [2:0] TPDI_CH_Z1 = 3'h3;
  localparam logic [2:0] TPDI_CH_Z2 = 3'h4;
  localparam logic [2:0] TPDI_CH_X = 3'h5;

  // Link clock counts: 8 command clocks, one busy clock, then result bits.
  // Result bit 1 is the next to last bit; 12-bit ends at 20, 8-bit at 16.
  localparam logic [4:0] TPDI_CNT_RST = 5'h00;
  localparam logic [4:0] TPDI_CMD_LAST = 5'h08;
  localparam logic [4:0] TPDI_END12 = 5'h14;
  localparam logic [4:0] TPDI_END8 = 5'h10;

  localparam logic TPDI_PDSEL_RST = 1'b0;
  localparam logic TPDI_REFPWR_RST = 1'b0;

  typedef enum logic [2:0] {
    TPDI_IDLE = 3'b001,
    TPDI_CONV_POS = 3'b010,
    TPDI_CONV_AUX = 3'b100
  } tpdi_state_t;

  // Pin controls toward the analog panel switches.
  typedef struct packed {
    logic y_neg_gnd_on;
    logic xpos_gate_on;
    logic detect_en;
    logic irq_force_high;
  } tpdi_panel_t;

endpackage

// file: rtl/tpdi_sync.sv
// Two-flop level synchroniser into the system clock domain.
`timescale 1ns/1ps
module tpdi_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule

// file: rtl/tpdi_top.sv
// Pen touch detection and interrupt logic with serial command capture.
`timescale 1ns/1ps
module tpdi_top
  import tpdi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_serial_bit_clock,
  input wire logic i_cs_n,
  input wire logic i_din,
  input wire logic i_xpos_level,
  output logic o_pen_touch_irq_n,
  output logic o_y_neg_gnd_on,
  output logic o_xpos_gate_on,
  output logic o_busy_conv,
  output logic o_reference_power_bit,
  output logic o_powerdown_select_bit
);

  function automatic logic tpdi_is_position(input logic [2:0] ch);
    return (ch == TPDI_CH_X) || (ch == TPDI_CH_Y) ||
           (ch == TPDI_CH_Z1) || (ch == TPDI_CH_Z2);
  endfunction

  // ---- Link domain: runs on the serial bit clock. ----
  // Chip select is an async clear here, so deselect aborts at once even
  // while the bit clock stands still.
  logic [4:0] lk_cnt_r;
  logic [TPDI_CTRL_W-1:0] lk_shift_r;
  logic lk_started_r;
  logic lk_conv_tgl_r;
  logic lk_end_tgl_r;
  logic [TPDI_CTRL_W-1:0] lk_cmd_r;

  always_ff @(posedge i_serial_bit_clock or posedge i_cs_n) begin
    if (i_cs_n) begin
      lk_cnt_r <= TPDI_CNT_RST;
      lk_shift_r <= '0;
      lk_started_r <= 1'b0;
    end else if (!lk_started_r) begin
      if (i_din) begin
        lk_started_r <= 1'b1;
        lk_cnt_r <= 5'h01;
        lk_shift_r <= {{(TPDI_CTRL_W-1){1'b0}}, 1'b1};
      end
    end else begin
      lk_shift_r <= {lk_shift_r[TPDI_CTRL_W-2:0], i_din};
      lk_cnt_r <= lk_cnt_r + 5'h01;
    end
  end

  // Command and start toggle land on the eighth rising edge. The toggles
  // need a known start, but chip select must not clear them, as that would
  // fake an event. System reset clears them while the link clock stands
  // still, so its release, unrelated to the link clock, does no harm.
  always_ff @(posedge i_serial_bit_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      lk_cmd_r <= '0;
      lk_conv_tgl_r <= 1'b0;
    end else if (lk_started_r && lk_cnt_r == TPDI_CMD_LAST - 5'h01 &&
                 !i_cs_n) begin
      lk_cmd_r <= {lk_shift_r[TPDI_CTRL_W-2:0], i_din};
      lk_conv_tgl_r <= ~lk_conv_tgl_r;
    end
  end

  // End of conversion on the falling edge after result bit 1.
  always_ff @(negedge i_serial_bit_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      lk_end_tgl_r <= 1'b0;
    end else if (!i_cs_n && lk_started_r &&
        lk_cnt_r == (lk_cmd_r[TPDI_MODE8_POS] ? TPDI_END8 : TPDI_END12)) begin
      lk_end_tgl_r <= ~lk_end_tgl_r;
    end
  end

  // ---- System domain. ----
  logic [3:0] sy_in;
  logic [3:0] sy_out;
  logic conv_tgl_d_r;
  logic end_tgl_d_r;
  logic [TPDI_CTRL_W-1:0] cmd_sync_r;
  logic cmd_hold_r;
  tpdi_state_t state_r;
  tpdi_state_t state_nxt;
  tpdi_panel_t panel_nxt;

  assign sy_in = {lk_conv_tgl_r, lk_end_tgl_r, i_cs_n, i_xpos_level};

  // The two pin bits clear to their idle high level, so that neither a
  // false touch nor a false select shows in the cycles after reset.
  tpdi_sync #(.WIDTH(4), .RST_VAL(4'h3)) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async(sy_in),
    .o_sync(sy_out)
  );

  logic conv_start;
  logic conv_end;
  logic cs_n_s;
  logic xpos_s;
  assign conv_start = sy_out[3] ^ conv_tgl_d_r;
  assign conv_end = sy_out[2] ^ end_tgl_d_r;
  assign cs_n_s = sy_out[1];
  assign xpos_s = sy_out[0];

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      conv_tgl_d_r <= 1'b0;
      end_tgl_d_r <= 1'b0;
    end else begin
      conv_tgl_d_r <= sy_out[3];
      end_tgl_d_r <= sy_out[2];
    end
  end

  // The command word is written on the same link edge as its toggle and
  // holds until the next byte, so a capture one cycle after the toggle is a safe word crossing.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cmd_hold_r <= 1'b0;
      cmd_sync_r <= '0;
    end else begin
      cmd_hold_r <= conv_start;
      if (cmd_hold_r) begin
        cmd_sync_r <= lk_cmd_r;
      end
    end
  end

  logic cmd_ready_r;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cmd_ready_r <= 1'b0;
    end else begin
      cmd_ready_r <= cmd_hold_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TPDI_IDLE: begin
        if (cmd_ready_r && !cs_n_s) begin
          state_nxt = tpdi_is_position(cmd_sync_r[TPDI_CHAN_HI:TPDI_CHAN_LO])
                    ? TPDI_CONV_POS : TPDI_CONV_AUX;
        end
      end
      TPDI_CONV_POS, TPDI_CONV_AUX: begin
        if (cs_n_s) begin
          state_nxt = TPDI_IDLE;
        end else if (conv_end) begin
          state_nxt = TPDI_IDLE;
        end
      end
      default: state_nxt = TPDI_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_r <= TPDI_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Power bits follow the most recent byte; deselect leaves them alone.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_powerdown_select_bit <= TPDI_PDSEL_RST;
      o_reference_power_bit <= TPDI_REFPWR_RST;
    end else if (cmd_ready_r) begin
      o_powerdown_select_bit <= cmd_sync_r[TPDI_PDSEL_POS];
      o_reference_power_bit <= cmd_sync_r[TPDI_REFPWR_POS];
    end
  end

  always_comb begin
    panel_nxt = '0;
    case (state_nxt)
      TPDI_IDLE: begin
        panel_nxt.y_neg_gnd_on = !o_powerdown_select_bit;
        panel_nxt.detect_en = !o_powerdown_select_bit;
        panel_nxt.xpos_gate_on = !o_powerdown_select_bit;
      end
      TPDI_CONV_POS: panel_nxt.irq_force_high = 1'b0;
      TPDI_CONV_AUX: panel_nxt.irq_force_high = 1'b1;
      default: panel_nxt = '0;
    endcase
  end

  // Unlatched: while detect_en is set (idle, powerdown select bit low), the output tracks the synchronised X+ level (~3 cycles).
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_pen_touch_irq_n <= 1'b1;
      o_y_neg_gnd_on <= 1'b0;
      o_xpos_gate_on <= 1'b0;
      o_busy_conv <= 1'b0;
    end else begin
      o_y_neg_gnd_on <= panel_nxt.y_neg_gnd_on;
      o_xpos_gate_on <= panel_nxt.xpos_gate_on;
      o_busy_conv <= (state_nxt != TPDI_IDLE);
      if (panel_nxt.detect_en) begin
        o_pen_touch_irq_n <= xpos_s;
      end else if (state_nxt == TPDI_IDLE) begin
        o_pen_touch_irq_n <= 1'b1;
      end else begin
        o_pen_touch_irq_n <= panel_nxt.irq_force_high;
      end
    end
  end

endmodule

// file: test/tpdi_host_model.sv
// Host model that sends serial control frames to the touch block.
`timescale 1ns/1ps
module tpdi_host_model (
  output logic o_serial_bit_clock,
  output logic o_cs_n,
  output logic o_din,
  output logic o_irq_masked
);
  initial begin
    o_serial_bit_clock = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
    o_irq_masked = 1'b0;
  end
  // The link clock stands low between frames; n edges under 20 cut a 12-bit frame short, under 16 an 8-bit one.
  task automatic frame(input logic [7:0] b, input int n);
    o_irq_masked = 1'b1;
    o_cs_n = 1'b0;
    #7;
    for (int i = 0; i < n; i++) begin
      o_din = (i < 8) ? b[7-i] : 1'b0;
      #3 o_serial_bit_clock = 1'b1;
      #3 o_serial_bit_clock = 1'b0;
    end
    #4 o_cs_n = 1'b1;
    o_irq_masked = 1'b0;
  endtask
endmodule

// file: test/tpdi_top_props.sv
// Port assertions for the touch detect block.
`timescale 1ns/1ps
module tpdi_top_props (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_serial_bit_clock,
  input wire logic i_cs_n,
  input wire logic i_din,
  input wire logic i_xpos_level,
  input wire logic o_pen_touch_irq_n,
  input wire logic o_y_neg_gnd_on,
  input wire logic o_xpos_gate_on,
  input wire logic o_busy_conv,
  input wire logic o_reference_power_bit,
  input wire logic o_powerdown_select_bit
);
  wire bz = o_busy_conv;
  wire irq = o_pen_touch_irq_n;
  wire on2 = o_y_neg_gnd_on && o_xpos_gate_on;
  wire off2 = !o_y_neg_gnd_on && !o_xpos_gate_on;
  wire idle0 = !bz && !o_powerdown_select_bit;
  wire idle1 = !bz && o_powerdown_select_bit;
  wire [1:0] pwr = {o_reference_power_bit, o_powerdown_select_bit};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_gate_off; bz |-> off2; endproperty
  a_gate_off: assert property (p_gate_off) else $error("switch on");
  property p_idle_on; idle0[*3] |-> on2; endproperty
  a_idle_on: assert property (p_idle_on) else $error("switch off");
  // Three cycles of lag: two synchroniser flops and the output register.
  property p_track; idle0[*4] |-> irq == $past(i_xpos_level, 3); endproperty
  a_track: assert property (p_track) else $error("irq lag");
  property p_pd_off; idle1[*3] |-> irq && off2; endproperty
  a_pd_off: assert property (p_pd_off) else $error("detect on");
  property p_forced; bz[*3] |-> $stable(irq); endproperty
  a_forced: assert property (p_forced) else $error("irq moved");
  property p_bits; $changed(pwr) |-> ##[0:2] bz; endproperty
  a_bits: assert property (p_bits) else $error("bits moved");
  property p_end; $rose(bz) |-> ##[1:60] !bz; endproperty
  a_end: assert property (p_end) else $error("no end");
  property p_abort; i_cs_n[*8] |-> !bz; endproperty
  a_abort: assert property (p_abort) else $error("busy on");
  c_pos: cover property (bz && !irq);
  c_aux: cover property (bz && irq);
  c_touch: cover property (idle0 && !irq);
endmodule
bind tpdi_top tpdi_top_props u_props (.*);

// file: test/tpdi_top_tb.sv
// Self-checking bench for the touch detect block.
`timescale 1ns/1ps
module tpdi_top_tb;
  import tpdi_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic xpos = 1'b1;
  logic sbc, cs_n, din, irq_n, gnd, gate, busy, refb, pdb;
  int miscompares = 0;
  int comparisons = 0;
  always #2.5 i_clk = ~i_clk;
  tpdi_host_model host (.o_serial_bit_clock(sbc), .o_cs_n(cs_n),
    .o_din(din), .o_irq_masked());
  tpdi_top dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_serial_bit_clock(sbc), .i_cs_n(cs_n), .i_din(din),
    .i_xpos_level(xpos), .o_pen_touch_irq_n(irq_n),
    .o_y_neg_gnd_on(gnd), .o_xpos_gate_on(gate), .o_busy_conv(busy),
    .o_reference_power_bit(refb), .o_powerdown_select_bit(pdb));
  task automatic check(input string s, input logic [2:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic settle(input logic v);
    @(posedge i_clk) xpos <= v;
    repeat (6) @(negedge i_clk);
  endtask
  task automatic wait_busy(input logic v);
    for (int n = 0; n < 60 && busy !== v; n++) @(negedge i_clk);
    check("busy", busy, v);
  endtask
  task automatic t_detect();
    settle(1'b1);
    check("switches", {gnd, gate}, 3'h3);
    settle(1'b0);
    check("touch", irq_n, 1'b0);
    settle(1'b1);
    check("release", irq_n, 1'b1);
  endtask
  // Panel level is set against the forced level so a leak would show.
  task automatic t_conv(input logic [2:0] ch, input logic [1:0] pw);
    logic pos;
    pos = ch inside {TPDI_CH_Y, TPDI_CH_Z1, TPDI_CH_Z2, TPDI_CH_X};
    settle(pos);
    fork
      host.frame({1'b1, ch, ch[0], 1'b0, pw}, ch[0] ? 16 : 20);
      begin
        wait_busy(1'b1);
        check("forced", irq_n, !pos);
        check("gates", {gnd, gate}, 3'h0);
      end
    join
    @(negedge i_clk);
    check("early end", busy, 1'b1);
    wait_busy(1'b0);
    repeat (6) @(negedge i_clk);
    check("bits", {refb, pdb}, pw);
    check("idle", {irq_n, gnd, gate}, {pos | pw[0], {2{!pw[0]}}});
  endtask
  task automatic t_abort();
    host.frame(8'hD0, 5);
    repeat (10) @(negedge i_clk);
    check("short frame", {busy, refb, pdb}, 3'h2);
    host.frame({1'b1, TPDI_CH_X, 4'h2}, 14);
    wait_busy(1'b0);
    check("ref kept", {refb, pdb}, 3'h2);
    settle(1'b0);
    check("after abort", irq_n, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_detect();
    for (int c = 0; c < 8; c++) t_conv(c[2:0], 2'b00);
    t_conv(3'h0, 2'b11);
    t_conv(3'h2, 2'b10);
    t_abort();
    complete_run();
  end
  // Twelve frames need about 2.4 us; eight times that means a hang.
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
endmodule
